// ===== core/hppc_consts.svh
`ifndef HPPC_CONSTS_SVH
`define HPPC_CONSTS_SVH

// polarity bit value meaning active-low sense
`define HPPC_POL_LOW 1'b0
// reset values of configuration
`define HPPC_RST_DIR 3'h0
`define HPPC_RST_DOUT 3'h0
// bit positions of the three port lines in the gpio vectors
`define HPPC_B13 0
`define HPPC_B14 1
`define HPPC_B15 2
`endif

// ===== core/hppc_pkg.sv
package hppc_pkg;
  // pin function selected for the host port
  typedef enum logic [1:0] {
    HPPC_FN_GPIO = 2'b00,
    HPPC_FN_HOST = 2'b01,
    HPPC_FN_OFF = 2'b10
  } hppc_fn_e;
  // polarity bits, 1 means active-high sense
  typedef struct packed {
    logic cs_pol;
    logic req_pol;
    logic rrq_pol;
    logic ack_pol;
  } hppc_pol_s;
  // bus shape settings from the host port control register
  typedef struct packed {
    hppc_fn_e fn;
    logic mux_bus;
    logic dual_req;
    logic req_od;
    logic gpio14_en;
  } hppc_cfg_s;
  // one two-way pin at the device edge
  typedef struct packed {
    logic o;
    logic oe;
  } hppc_pin_s;
endpackage

// ===== core/hppc_pol_sync.sv
`timescale 1ns/1ps
`include "hppc_consts.svh"
// polarity stage: xor the inverted configuration bit with the active-high signal
module hppc_pol_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pol_in,
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] conv
);
  // registered conversion; pol low means pin active-low
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      conv <= '0;
    end else begin
      conv <= raw ^ ~pol_in;
    end
  end
endmodule

// ===== core/hppc_top.sv
`timescale 1ns/1ps
`include "hppc_consts.svh"
// pin function and polarity logic for chip select, requests, acknowledge
module hppc_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input hppc_pkg::hppc_cfg_s cfg_in,
  input wire logic cfg_we,
  input hppc_pkg::hppc_pol_s pol_in,
  input wire logic pol_we,
  input wire logic [2:0] dir_in,
  input wire logic dir_we,
  input wire logic [2:0] gpio_dout_in,
  input wire logic dout_we,
  input wire logic req_int,
  input wire logic rrq_int,
  input wire logic pin13_in,
  input wire logic pin14_in,
  input wire logic pin15_in,
  output hppc_pkg::hppc_pin_s pin14_drv,
  output hppc_pkg::hppc_pin_s pin15_drv,
  output hppc_pkg::hppc_pin_s pin13_drv,
  output logic host_chip_select,
  output logic host_addr_line_ten,
  output logic host_acknowledge_in,
  output logic [2:0] gpio_din,
  output hppc_pkg::hppc_cfg_s cfg_q,
  output hppc_pkg::hppc_pol_s pol_q
);
  import hppc_pkg::*;

  logic [2:0] host_direction_reg; // 1 = output
  logic [2:0] gpio_dout; // gpio output latches
  logic host_mode; // host function selected
  logic gpio_mode; // lines 13 and 15 general-purpose
  logic [1:0] req_conv; // request pair after polarity
  logic req_d; // tx/single request pin value
  logic rrq_d; // receive request pin value
  logic req_oe_d; // request pin enable
  logic rrq_oe_d; // receive request pin enable
  logic [2:0] gpio_ok; // per-line gpio availability
  logic [2:0] pins_in; // gathered pin inputs
  logic [1:0] sel_pol; // polarity bits for requests

  assign host_mode = (cfg_q.fn == HPPC_FN_HOST);
  assign gpio_mode = (cfg_q.fn == HPPC_FN_GPIO);
  assign pins_in = {pin15_in, pin14_in, pin13_in};
  assign sel_pol = {pol_q.rrq_pol, pol_q.req_pol};

  // host port control register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_q <= '{fn: HPPC_FN_GPIO, mux_bus: 1'b0, dual_req: 1'b0,
                 req_od: 1'b0, gpio14_en: 1'b0};
    end else if (cfg_we) begin
      cfg_q <= cfg_in;
    end
  end

  // polarity bits, reset to active-low sense
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pol_q <= '{`HPPC_POL_LOW, `HPPC_POL_LOW, `HPPC_POL_LOW, `HPPC_POL_LOW};
    end else if (pol_we) begin
      pol_q <= pol_in;
    end
  end

  // direction register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      host_direction_reg <= `HPPC_RST_DIR;
    end else if (dir_we) begin
      host_direction_reg <= dir_in;
    end
  end

  // gpio output latches
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gpio_dout <= `HPPC_RST_DOUT;
    end else if (dout_we) begin
      gpio_dout <= gpio_dout_in;
    end
  end

  // request polarity conversion, registered
  hppc_pol_sync #(
    .WIDTH(2)
  ) u_req_pol (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pol_in(sel_pol),
    .raw({rrq_int, req_int}),
    .conv(req_conv)
  );

  // per-line general-purpose availability
  always_comb begin
    gpio_ok[`HPPC_B13] = gpio_mode;
    gpio_ok[`HPPC_B15] = gpio_mode;
    gpio_ok[`HPPC_B14] = cfg_q.mux_bus && cfg_q.gpio14_en;
  end

  // request pin values and enables
  always_comb begin
    req_d = 1'b0;
    rrq_d = 1'b0;
    req_oe_d = 1'b0;
    rrq_oe_d = 1'b0;
    if (host_mode) begin
      // single request or transmit request on the same pin
      req_d = req_conv[0];
      // open drain: drive only when pulling low
      req_oe_d = cfg_q.req_od ? ~req_conv[0] : 1'b1;
      if (cfg_q.dual_req) begin
        rrq_d = req_conv[1];
        rrq_oe_d = cfg_q.req_od ? ~req_conv[1] : 1'b1;
      end
    end
  end

  // pin14 drive: host request, or gpio
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin14_drv <= '0;
    end else if (host_mode && !gpio_ok[`HPPC_B14]) begin
      pin14_drv <= '{o: req_d, oe: req_oe_d};
    end else begin
      pin14_drv <= '{o: gpio_dout[`HPPC_B14],
                     oe: gpio_ok[`HPPC_B14] & host_direction_reg[`HPPC_B14]};
    end
  end

  // pin15 drive: receive request in dual host mode, undriven in single host mode, else gpio
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin15_drv <= '0;
    end else if (host_mode) begin
      pin15_drv <= '{o: rrq_d, oe: rrq_oe_d};
    end else begin
      pin15_drv <= '{o: gpio_dout[`HPPC_B15],
                     oe: gpio_ok[`HPPC_B15] & host_direction_reg[`HPPC_B15]};
    end
  end

  // pin13 is never driven in host mode, input only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin13_drv <= '0;
    end else begin
      pin13_drv <= '{o: gpio_dout[`HPPC_B13],
                     oe: gpio_ok[`HPPC_B13] & host_direction_reg[`HPPC_B13]};
    end
  end

  // pin13 as chip select or address ten
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      host_chip_select <= 1'b0;
      host_addr_line_ten <= 1'b0;
    end else begin
      host_chip_select <= host_mode && !cfg_q.mux_bus
                          && (pin13_in ^ ~pol_q.cs_pol);
      host_addr_line_ten <= host_mode && cfg_q.mux_bus && pin13_in;
    end
  end

  // acknowledge on pin15 in single-request host mode
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      host_acknowledge_in <= 1'b0;
    end else begin
      host_acknowledge_in <= host_mode && !cfg_q.dual_req
                             && (pin15_in ^ ~pol_q.ack_pol);
    end
  end

  // gpio input sampling, zero when unavailable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gpio_din <= '0;
    end else begin
      gpio_din <= pins_in & gpio_ok;
    end
  end

  // assertions
  property p_cs_level;
    @(posedge mclk) disable iff (sys_rst)
      (host_mode && !cfg_q.mux_bus && $stable(cfg_q) && $stable(pol_q))
      |=> (host_chip_select == ($past(pin13_in) ^ ~$past(pol_q.cs_pol)));
  endproperty
  a_cs_level: assert property (p_cs_level) else $error("chip select wrong");

  property p_a10;
    @(posedge mclk) disable iff (sys_rst)
      (host_mode && cfg_q.mux_bus && $stable(cfg_q))
      |=> (!host_chip_select && (host_addr_line_ten == $past(pin13_in)));
  endproperty
  a_a10: assert property (p_a10) else $error("chip select in mux mode");

  property p_gpio13;
    @(posedge mclk) disable iff (sys_rst)
      (!gpio_mode && $stable(cfg_q)) |=> !pin13_drv.oe;
  endproperty
  a_gpio13: assert property (p_gpio13) else $error("line 13 driven");

  property p_od;
    @(posedge mclk) disable iff (sys_rst)
      (host_mode && cfg_q.req_od && !gpio_ok[`HPPC_B14] && $stable(cfg_q))
      |=> !(pin14_drv.oe && pin14_drv.o);
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");

  property p_single_rrq;
    @(posedge mclk) disable iff (sys_rst)
      (host_mode && !cfg_q.dual_req && $stable(cfg_q)) |=> !pin15_drv.oe;
  endproperty
  a_single_rrq: assert property (p_single_rrq) else $error("ack pin driven");

  property p_g14;
    @(posedge mclk) disable iff (sys_rst)
      !(cfg_q.mux_bus && cfg_q.gpio14_en) |=> (gpio_din[`HPPC_B14] == 1'b0);
  endproperty
  a_g14: assert property (p_g14) else $error("line 14 gpio not allowed");

  sequence s_req_rise;
    host_mode && !cfg_q.dual_req && $stable(cfg_q) && $stable(pol_q)
      && req_int && !cfg_q.req_od && !gpio_ok[`HPPC_B14];
  endsequence
  property p_req;
    @(posedge mclk) disable iff (sys_rst)
      s_req_rise ##1 (host_mode && $stable(cfg_q))
      |=> (pin14_drv.o == $past(pol_q.req_pol, 2));
  endproperty
  a_req: assert property (p_req) else $error("request level wrong");

  property p_rrq;
    @(posedge mclk) disable iff (sys_rst)
      (host_mode && cfg_q.dual_req && !cfg_q.req_od && rrq_int
        && $stable(cfg_q) && $stable(pol_q)) ##1 ($stable(cfg_q) && $stable(pol_q))
      |=> (pin15_drv.o == $past(pol_q.rrq_pol, 2)) && pin15_drv.oe;
  endproperty
  a_rrq: assert property (p_rrq) else $error("receive request wrong");

  property p_rst_pol;
    @(posedge mclk) $fell(sys_rst) |-> (pol_q == '0);
  endproperty
  a_rst_pol: assert property (p_rst_pol) else $error("reset polarity not low");
endmodule

// ===== verif/hppc_host_model.sv
`timescale 1ns/1ps
// host processor on the far side: drives chip select, answers requests
module hppc_host_model (
  input wire logic mclk,
  input wire logic req_wire,
  input wire logic req_act,
  input wire logic ack_act,
  input wire logic [3:0] ack_dly,
  input wire logic cs_on,
  input wire logic cs_act,
  output logic cs_pin,
  output logic ack_pin
);
  logic [3:0] cnt; // cycles the request has been seen active
  // chip select level in the sense the device expects
  assign cs_pin = cs_on ? cs_act : ~cs_act;
  // acknowledge after a chosen delay, dropped once request goes away
  always_ff @(posedge mclk) begin
    if (req_wire !== req_act) begin
      cnt <= 4'h0;
      ack_pin <= ~ack_act;
    end else if (cnt == ack_dly) begin
      ack_pin <= ack_act;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ===== verif/tb_host_port_pin_config.sv
`timescale 1ns/1ps
module tb_host_port_pin_config;
  import hppc_pkg::*;
  logic mclk, sys_rst, cfg_we, pol_we, dir_we, dout_we, req_int, rrq_int;
  hppc_cfg_s cfg_in, cfg_q; // control write and readback
  hppc_pol_s pol_in, pol_q; // polarity write and readback
  hppc_pin_s p13, p14, p15; // pin drives
  logic [2:0] dir_in, gpio_dout_in, gpio_din, tb_pin;
  logic chip_sel, addr_ten, ack_dec, host_on, cs_on, cs_pin, ack_pin;
  logic w13, w14, w15; // resolved pin levels
  logic [3:0] ack_dly;
  int error_cnt, tests_run;
  // clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // a driving device wins, else the host or bench; request line pulled up
  assign w13 = p13.oe ? p13.o : (host_on ? cs_pin : tb_pin[0]);
  assign w14 = p14.oe ? p14.o : (host_on ? 1'b1 : tb_pin[1]);
  assign w15 = p15.oe ? p15.o : (host_on ? ack_pin : tb_pin[2]);
  hppc_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .cfg_in(cfg_in),
    .cfg_we(cfg_we), .pol_in(pol_in), .pol_we(pol_we), .dir_in(dir_in),
    .dir_we(dir_we), .gpio_dout_in(gpio_dout_in), .dout_we(dout_we),
    .req_int(req_int), .rrq_int(rrq_int), .pin13_in(w13), .pin14_in(w14),
    .pin15_in(w15), .pin14_drv(p14), .pin15_drv(p15), .pin13_drv(p13),
    .host_chip_select(chip_sel), .host_addr_line_ten(addr_ten),
    .host_acknowledge_in(ack_dec), .gpio_din(gpio_din), .cfg_q(cfg_q),
    .pol_q(pol_q));
  hppc_host_model u_host (.mclk(mclk), .req_wire(w14),
    .req_act(pol_in.req_pol), .ack_act(pol_in.ack_pol), .ack_dly(ack_dly),
    .cs_on(cs_on), .cs_act(pol_in.cs_pol), .cs_pin(cs_pin), .ack_pin(ack_pin));
  // compare one value
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // verdict and end of run
  task automatic give_verdict;
    if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // load all settings in the same cycle, then let outputs settle
  task automatic ld(input logic [5:0] c, input logic [3:0] p, input logic [5:0] d);
    cfg_in = c;
    pol_in = p;
    {dir_in, gpio_dout_in} = d;
    {cfg_we, pol_we, dir_we, dout_we} = 4'hf;
    @(negedge mclk);
    {cfg_we, pol_we, dir_we, dout_we} = 4'h0;
    repeat (4) @(negedge mclk);
  endtask
  // defaults after reset
  task automatic t_reset;
    chk("cfg", 8'h00, 8'(cfg_q));
    chk("pol", 8'h00, 8'(pol_q));
    chk("pins", 8'h00, 8'({p13, p14, p15}));
  endtask
  // chip select and address ten on the shared pin
  task automatic t_cs;
    host_on = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 2; a++) begin
        cs_on = a[0];
        ld(6'h10, {p[0], 3'h0}, 6'h0);
        chk("cs", 8'(a[0]), 8'(chip_sel));
        chk("pol", 8'({p[0], 3'h0}), 8'(pol_q));
        chk("p13", 8'h00, 8'(p13));
      end
    end
    for (int a = 0; a < 2; a++) begin
      cs_on = a[0];
      ld(6'h18, 4'h0, 6'h0);
      chk("a10", 8'(!a[0]), 8'(addr_ten));
      chk("cs", 8'h00, 8'(chip_sel));
      chk("cfg", 8'h18, 8'(cfg_q));
    end
  endtask
  // general-purpose lines
  task automatic t_gpio;
    host_on = 1'b0;
    tb_pin = 3'b111;
    ld(6'h00, 4'h0, 6'h29);
    chk("p13", 8'h03, 8'(p13));
    chk("p15", 8'h01, 8'(p15));
    chk("p14", 8'h00, 8'(p14));
    ld(6'h00, 4'h0, 6'h00);
    chk("din", 8'h05, 8'(gpio_din));
    ld(6'h09, 4'h0, 6'h00);
    chk("din", 8'h07, 8'(gpio_din));
    ld(6'h09, 4'h0, 6'h12);
    chk("p14", 8'h03, 8'(p14));
    // host function on a multiplexed bus with line 14 kept as gpio
    ld(6'h19, 4'h0, 6'h12);
    chk("p14", 8'h03, 8'(p14));
    chk("din", 8'h02, 8'(gpio_din));
    // port switched off: nothing driven, nothing sampled
    ld(6'h20, 4'h0, 6'h3f);
    chk("p13", 8'h02, 8'(p13));
    chk("p14", 8'h02, 8'(p14));
    chk("p15", 8'h02, 8'(p15));
    chk("din", 8'h00, 8'(gpio_din));
  endtask
  // request outputs in single and dual mode, driven and open drain
  task automatic t_req;
    logic e;
    host_on = 1'b1;
    for (int d = 0; d < 2; d++) begin
      for (int p = 0; p < 2; p++) begin
        for (int od = 0; od < 4; od += 2) begin
          for (int r = 0; r < 2; r++) begin
            req_int = r[0];
            rrq_int = !r[0];
            ld(6'h10 | 6'(d * 4 + od), {1'b0, p[0], p[0], 1'b0}, 6'h0);
            e = r[0] ? p[0] : !p[0];
            chk("req", 8'({e, od == 0 || !e}), 8'(p14));
            chk("rrq", d ? 8'({!e, od == 0 || e}) : 8'h00, 8'(p15));
          end
        end
      end
    end
  endtask
  // request answered by host acknowledge, prompt and slow
  task automatic t_hs;
    host_on = 1'b1;
    for (int k = 0; k < 2; k++) begin
      ack_dly = k ? 4'h6 : 4'h1;
      req_int = 1'b0;
      ld(6'h10, {2'h0, 1'b0, k[0]}, 6'h0);
      req_int = 1'b1;
      for (int i = 0; i < 30 && ack_dec !== 1'b1; i++) @(negedge mclk);
      chk("ack", 8'h01, 8'(ack_dec));
      if (ack_dec !== 1'b1) give_verdict();
      req_int = 1'b0;
      repeat (5) @(negedge mclk);
      chk("ack", 8'h00, 8'(ack_dec));
    end
  endtask
  // main sequence
  initial begin
    {sys_rst, cfg_we, pol_we, dir_we, dout_we, req_int, rrq_int} = 7'h40;
    {host_on, cs_on, tb_pin, ack_dly} = 9'h0;
    cfg_in = '0;
    pol_in = '0;
    {dir_in, gpio_dout_in} = 6'h0;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    t_reset();
    t_cs();
    t_gpio();
    t_req();
    t_hs();
    give_verdict();
  end
endmodule
